/* hw/smr_ctrl.sv */
// memory controller end: power-up order, mode writes, leveling exit
//
// Decided for this implementation: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module smr_ctrl #(
    parameter int CKE_LOW_CYCLES = smr_pkg::CKE_LOW_CYC
) (
    // clock, reset, enable
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic ce,
    // apb slave
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // memory link
    smr_link_if.ctrl link
);
    import smr_pkg::*;

    smr_ctl_t ctl_ff;
    smr_ctl_t nxt_ctl;

    // park in the wait state for n cycles, then go on
    function automatic smr_ctl_t go_wait(smr_ctl_t c, int n, smr_cst_t s);
        smr_ctl_t r;
        r = c;
        r.cnt = CNT_W'(n);
        r.after = s;
        r.st = S_WAIT;
        return r;
    endfunction

    // one mode write, full register value every time
    function automatic smr_ctl_t put_mode(smr_ctl_t c, logic [1:0] idx,
                                          logic [ADDR_W-1:0] val);
        smr_ctl_t r;
        r = c;
        r.cmd = CMD_MODE_WRITE;
        r.ba = {1'b0, idx};
        r.addr = val;
        r.term = 1'b0;
        return r;
    endfunction

    always_comb begin
        logic [REQ_W-1:0] set_req;
        logic mode_page;
        set_req = '0;
        mode_page = (paddr[7:4] == ADDR_MODE_PAGE);
        nxt_ctl = ctl_ff;
        nxt_ctl.cmd = CMD_NOP;
        nxt_ctl.pready = 1'b0;
        nxt_ctl.ready = 1'b0;

        // apb setup: prepare the answer for the access cycle
        if (psel && !penable) begin
            nxt_ctl.pready = 1'b1;
            nxt_ctl.pslverr = 1'b0;
            nxt_ctl.prdata = '0;
            if (paddr == ADDR_CTRL) begin
                nxt_ctl.prdata[REQ_W-1:0] = ctl_ff.req;
            end else if (paddr == ADDR_STAT) begin
                nxt_ctl.prdata = {19'h0, ctl_ff.st, 5'h0,
                                  ctl_ff.st == S_IDLE, ctl_ff.lvl_result,
                                  ctl_ff.ready};
            end else if (mode_page && paddr[1:0] == 2'h0) begin
                nxt_ctl.prdata[ADDR_W-1:0] = ctl_ff.mode[paddr[3:2]];
            end else begin
                nxt_ctl.pslverr = 1'b1; // unmapped, nothing stored
            end
        end
        // apb access: writes land at the pready edge only
        if (psel && penable && ctl_ff.pready && pwrite && !ctl_ff.pslverr) begin
            if (paddr == ADDR_CTRL) begin
                set_req = pwdata[REQ_W-1:0];
            end else if (mode_page) begin
                nxt_ctl.mode[paddr[3:2]] = pwdata[ADDR_W-1:0];
            end
        end

        // sequencer
        case (ctl_ff.st)
            S_IDLE: begin
                nxt_ctl.mem_rst_n = 1'b0;
                nxt_ctl.cke = 1'b0;
                nxt_ctl.term = 1'b0;
                if (ctl_ff.req[REQ_INIT]) begin
                    nxt_ctl.req[REQ_INIT] = 1'b0;
                    nxt_ctl = go_wait(nxt_ctl, RST_LOW_CYC, S_RELEASE);
                end
            end
            S_RELEASE: begin
                // cke has been low far longer than the 10ns lead
                nxt_ctl.mem_rst_n = 1'b1;
                nxt_ctl = go_wait(nxt_ctl, CKE_LOW_CYCLES, S_CKE_UP);
            end
            S_CKE_UP: begin
                // clock runs free, so the valid-clock lead is long met
                nxt_ctl.cke = 1'b1;
                nxt_ctl = go_wait(nxt_ctl, RST_EXIT_CYC, S_MODE2);
            end
            S_MODE2: begin
                nxt_ctl = put_mode(nxt_ctl, MODE_REG_TWO,
                                   ctl_ff.mode[MODE_REG_TWO]);
                nxt_ctl = go_wait(nxt_ctl, MODE_GAP_CYC, S_MODE3);
            end
            S_MODE3: begin
                nxt_ctl = put_mode(nxt_ctl, MODE_REG_THREE,
                                   ctl_ff.mode[MODE_REG_THREE]);
                nxt_ctl = go_wait(nxt_ctl, MODE_GAP_CYC, S_MODE1);
            end
            S_MODE1: begin
                // dll enabled, termination as software configured
                nxt_ctl = put_mode(nxt_ctl, MODE_REG_ONE,
                    ctl_ff.mode[MODE_REG_ONE] &
                    ~(ADDR_W'(1) << DLL_DIS_BIT));
                nxt_ctl = go_wait(nxt_ctl, MODE_GAP_CYC, S_MODE0);
            end
            S_MODE0: begin
                nxt_ctl = put_mode(nxt_ctl, MODE_REG_ZERO,
                    ctl_ff.mode[MODE_REG_ZERO] |
                    (ADDR_W'(1) << DLL_RST_BIT));
                nxt_ctl = go_wait(nxt_ctl, MODE_UPD_CYC, S_CALIB);
            end
            S_CALIB: begin
                nxt_ctl.cmd = CMD_CALIB;
                nxt_ctl.addr = ADDR_W'(1) << CALIB_LONG_BIT;
                // waiting from here covers the lock counted from mode zero
                nxt_ctl = go_wait(nxt_ctl, LOCK_WAIT_CYC, S_READY);
            end
            S_READY: begin
                // no row commands are issued, so banks stay precharged
                if (ctl_ff.req[REQ_LVL_IN]) begin
                    nxt_ctl.req[REQ_LVL_IN] = 1'b0;
                    nxt_ctl.st = S_LVL_IN;
                end else if (ctl_ff.req[REQ_VSW]) begin
                    nxt_ctl.req[REQ_VSW] = 1'b0;
                    nxt_ctl.st = S_VHOLD;
                end else begin
                    nxt_ctl.ready = 1'b1;
                end
            end
            S_LVL_IN: begin
                // dll must stay enabled while leveling
                nxt_ctl = put_mode(nxt_ctl, MODE_REG_ONE,
                    (ctl_ff.mode[MODE_REG_ONE] & ~(ADDR_W'(1) << DLL_DIS_BIT))
                    | (ADDR_W'(1) << LVL_BIT));
                nxt_ctl = go_wait(nxt_ctl, MODE_UPD_CYC, S_LVL);
            end
            S_LVL: begin
                // terminate the strobe and toggle it each cycle
                nxt_ctl.term = 1'b1;
                nxt_ctl.dqs_oe = 1'b1;
                nxt_ctl.dqs_o = !ctl_ff.dqs_o;
                if (ctl_ff.req[REQ_LVL_OUT]) begin
                    nxt_ctl.req[REQ_LVL_OUT] = 1'b0;
                    nxt_ctl.dqs_o = 1'b0;
                    nxt_ctl = go_wait(nxt_ctl, LVL_OUT_CYC + CAPTURE_CYC,
                                      S_LVX_TERM);
                end
            end
            S_LVX_TERM: begin
                // strobe and termination drop on the same edge
                nxt_ctl.lvl_result = link.dq_o;
                nxt_ctl.dqs_oe = 1'b0;
                nxt_ctl.term = 1'b0;
                nxt_ctl = go_wait(nxt_ctl, TERM_OFF_CYC, S_LVX_MODE);
            end
            S_LVX_MODE: begin
                nxt_ctl = put_mode(nxt_ctl, MODE_REG_ONE,
                    ctl_ff.mode[MODE_REG_ONE] & ~(ADDR_W'(1) << LVL_BIT) &
                    ~(ADDR_W'(1) << DLL_DIS_BIT));
                nxt_ctl = go_wait(nxt_ctl, MODE_UPD_CYC, S_READY);
            end
            S_VHOLD: begin
                // only nops while the supply moves, then relock
                if (ctl_ff.req[REQ_VSTABLE]) begin
                    nxt_ctl.req[REQ_VSTABLE] = 1'b0;
                    nxt_ctl.st = S_MODE0;
                end
            end
            S_WAIT: begin
                // cke never falls here, so powerdown delays hold
                if (ctl_ff.cnt <= CNT_W'(1)) begin
                    nxt_ctl.st = ctl_ff.after;
                end else begin
                    nxt_ctl.cnt = ctl_ff.cnt - CNT_W'(1);
                end
            end
            default: begin
                nxt_ctl.st = S_IDLE;
            end
        endcase
        // a request written now survives the clear above
        nxt_ctl.req = nxt_ctl.req | set_req;
    end

    // single state register, frozen while ce is low
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            ctl_ff <= '0;
            ctl_ff.cmd <= CMD_NOP;
        end else if (ce) begin
            ctl_ff <= nxt_ctl;
        end
    end

    // outputs straight from the state register
    assign link.mem_rst_n = ctl_ff.mem_rst_n;
    assign link.cke = ctl_ff.cke;
    assign {link.cs_n, link.ras_n, link.cas_n, link.we_n} = ctl_ff.cmd;
    assign link.ba = ctl_ff.ba;
    assign link.addr = ctl_ff.addr;
    assign link.term_ctl = ctl_ff.term;
    assign link.dqs_o = ctl_ff.dqs_o;
    assign link.dqs_oe = ctl_ff.dqs_oe;
    assign prdata = ctl_ff.prdata;
    assign pready = ctl_ff.pready;
    assign pslverr = ctl_ff.pslverr;
endmodule // smr_ctrl
`default_nettype wire

/* hw/smr_dev.sv */
// memory device end: mode registers, dll lock, calibration, burst decode
`timescale 1ns/1ns
`default_nettype none
module smr_dev (
    // clock, reset, enable
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic ce,
    // memory link
    smr_link_if.dev link,
    // user side status
    output logic [3:0][smr_pkg::ADDR_W-1:0] mode_regs,
    output logic dll_locked,
    output logic calib_done,
    output logic dq_undefined,
    output logic burst_valid,
    output logic burst_eight,
    output logic [smr_pkg::COL_W-1:0] burst_block
);
    import smr_pkg::*;

    smr_dev_t dev_ff;
    smr_dev_t nxt_dev;

    // next state from the sampled link pins
    always_comb begin
        logic [3:0] cmd;
        logic lvl;
        cmd = {link.cs_n, link.ras_n, link.cas_n, link.we_n};
        lvl = dev_ff.mode[MODE_REG_ONE][LVL_BIT];
        nxt_dev = dev_ff;
        nxt_dev.bst_valid = 1'b0;
        if (!link.mem_rst_n) begin
            nxt_dev = '0;
        end else begin
            // dll reset bit starts the lock count and clears itself
            if (dev_ff.mode[MODE_REG_ZERO][DLL_RST_BIT]) begin
                nxt_dev.mode[MODE_REG_ZERO][DLL_RST_BIT] = 1'b0;
                nxt_dev.dll_cnt = CNT_W'(DLL_LOCK_CYC);
                nxt_dev.dll_run = 1'b1;
                nxt_dev.dll_lock = 1'b0;
            end else if (dev_ff.dll_run && link.cke) begin
                // lock counts only clocks with cke high
                if (dev_ff.dll_cnt <= CNT_W'(1)) begin
                    nxt_dev.dll_run = 1'b0;
                    nxt_dev.dll_lock = 1'b1;
                end else begin
                    nxt_dev.dll_cnt = dev_ff.dll_cnt - CNT_W'(1);
                end
            end
            // calibration timer
            if (dev_ff.cal_run) begin
                if (dev_ff.cal_cnt <= CNT_W'(1)) begin
                    nxt_dev.cal_run = 1'b0;
                    nxt_dev.cal_done = 1'b1;
                end else begin
                    nxt_dev.cal_cnt = dev_ff.cal_cnt - CNT_W'(1);
                end
            end
            // undefined only once a driven strobe is released, not on entry
            if (!lvl) begin
                nxt_dev.lvl_seen = 1'b0;
            end else if (link.dqs_oe) begin
                nxt_dev.lvl_seen = 1'b1;
            end else if (dev_ff.lvl_seen) begin
                nxt_dev.dq_undef = 1'b1;
            end
            if (dev_ff.upd_cnt != CNT_W'(0)) begin
                nxt_dev.upd_cnt = dev_ff.upd_cnt - CNT_W'(1);
                if (dev_ff.upd_cnt == CNT_W'(1)) begin
                    nxt_dev.dq_undef = 1'b0;
                end
            end
            // command decode, only while cke is registered high
            if (link.cke && !link.cs_n) begin
                case (cmd)
                    CMD_MODE_WRITE: begin
                        if (!link.ba[BA_W-1]) begin
                            // bank bits pick the target register
                            nxt_dev.mode[link.ba[1:0]] = link.addr;
                            if (link.ba[1:0] == MODE_REG_ONE && lvl &&
                                !link.addr[LVL_BIT]) begin
                                nxt_dev.upd_cnt = CNT_W'(MODE_UPD_CYC);
                            end
                        end
                    end
                    CMD_CALIB: begin
                        if (link.addr[CALIB_LONG_BIT]) begin
                            nxt_dev.cal_cnt = CNT_W'(CALIB_INIT_CYC);
                            nxt_dev.cal_run = 1'b1;
                            nxt_dev.cal_done = 1'b0;
                        end
                    end
                    CMD_READ, CMD_WRITE: begin
                        nxt_dev.bst_valid = 1'b1;
                        // fixed eight, or per command on the fly
                        nxt_dev.bst_eight =
                            (dev_ff.mode[MODE_REG_ZERO][1:0] == BL_FIXED8) ||
                            (dev_ff.mode[MODE_REG_ZERO][1:0] == BL_OTF &&
                             link.addr[BURST_SEL_BIT]);
                        // burst wraps inside an aligned column block
                        if (nxt_dev.bst_eight) begin
                            nxt_dev.bst_block =
                                {link.addr[COL_W-1:3], 3'h0};
                        end else begin
                            nxt_dev.bst_block =
                                {link.addr[COL_W-1:2], 2'h0};
                        end
                    end
                    default: begin
                    end
                endcase
            end
            // prime dq echoes the strobe sample, off while outputs disabled
            nxt_dev.dq_o = link.dqs_o;
            nxt_dev.dq_oe = lvl && !dev_ff.mode[MODE_REG_ONE][QOFF_BIT] &&
                !nxt_dev.dq_undef;
        end
    end

    // single state register, frozen while ce is low
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            dev_ff <= '0;
        end else if (ce) begin
            dev_ff <= nxt_dev;
        end
    end

    // outputs straight from the state register
    assign link.dq_o = dev_ff.dq_o;
    assign link.dq_oe = dev_ff.dq_oe;
    assign mode_regs = dev_ff.mode;
    assign dll_locked = dev_ff.dll_lock;
    assign calib_done = dev_ff.cal_done;
    assign dq_undefined = dev_ff.dq_undef;
    assign burst_valid = dev_ff.bst_valid;
    assign burst_eight = dev_ff.bst_eight;
    assign burst_block = dev_ff.bst_block;
endmodule // smr_dev
`default_nettype wire

/* include/smr_link_if.sv */
// command, clock-enable, termination and strobe link between both ends
`timescale 1ns/1ns
`default_nettype none
interface smr_link_if;
    logic mem_rst_n;
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [smr_pkg::BA_W-1:0] ba;
    logic [smr_pkg::ADDR_W-1:0] addr;
    logic term_ctl;
    logic dqs_o;
    logic dqs_oe;
    logic dq_o;
    logic dq_oe;

    modport ctrl (
        output mem_rst_n, cke, cs_n, ras_n, cas_n, we_n, ba, addr,
        output term_ctl, dqs_o, dqs_oe,
        input dq_o, dq_oe
    );
    modport dev (
        input mem_rst_n, cke, cs_n, ras_n, cas_n, we_n, ba, addr,
        input term_ctl, dqs_o, dqs_oe,
        output dq_o, dq_oe
    );
endinterface
`default_nettype wire

/* include/smr_pkg.sv */
// shared constants and types for the mode register sequencer link
`default_nettype none
package smr_pkg;
    // clock and timing, times in their own units
    localparam int CLK_NS = 100;
    localparam int RST_LOW_US = 200;
    localparam int RST_LOW_CYC = (RST_LOW_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int CKE_PRE_NS = 10;
    localparam int CKE_PRE_CYC = (CKE_PRE_NS + CLK_NS - 1) / CLK_NS;
    localparam int CKE_LOW_US = 500;
    localparam int CKE_LOW_CYC = (CKE_LOW_US * 1000) / CLK_NS - 1;
    localparam int CLK_VALID_NS = 10;
    localparam int CLK_VALID_MIN = 5;
    localparam int CLK_VALID_CYC = ((CLK_VALID_NS + CLK_NS - 1) / CLK_NS
        > CLK_VALID_MIN) ? (CLK_VALID_NS + CLK_NS - 1) / CLK_NS : CLK_VALID_MIN;
    localparam int DLL_LOCK_CYC = 512;
    localparam int CALIB_INIT_CYC = 512;
    localparam int LOCK_WAIT_CYC = (DLL_LOCK_CYC > CALIB_INIT_CYC) ?
        DLL_LOCK_CYC : CALIB_INIT_CYC;
    localparam int RST_EXIT_CYC = 8;
    localparam int MODE_GAP_CYC = 4;
    localparam int MODE_UPD_CYC = 12;
    localparam int LVL_OUT_CYC = 1;
    localparam int CAPTURE_CYC = 2;
    localparam int TERM_OFF_CYC = 2;
    localparam int CNT_W = 16;

    // link widths and command codes {cs_n, ras_n, cas_n, we_n}
    localparam int BA_W = 3;
    localparam int ADDR_W = 16;
    localparam int COL_W = 10;
    localparam logic [3:0] CMD_NOP = 4'h7;
    localparam logic [3:0] CMD_MODE_WRITE = 4'h0;
    localparam logic [3:0] CMD_CALIB = 4'h6;
    localparam logic [3:0] CMD_READ = 4'h5;
    localparam logic [3:0] CMD_WRITE = 4'h4;

    // mode register targets and fields
    localparam logic [1:0] MODE_REG_ZERO = 2'h0;
    localparam logic [1:0] MODE_REG_ONE = 2'h1;
    localparam logic [1:0] MODE_REG_TWO = 2'h2;
    localparam logic [1:0] MODE_REG_THREE = 2'h3;
    localparam int DLL_RST_BIT = 8;
    localparam int DLL_DIS_BIT = 0;
    localparam int LVL_BIT = 7;
    localparam int QOFF_BIT = 12;
    localparam int CALIB_LONG_BIT = 10;
    localparam int BURST_SEL_BIT = 12;
    localparam logic [1:0] BL_FIXED8 = 2'h0;
    localparam logic [1:0] BL_OTF = 2'h1;

    // controller register map and bits
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STAT = 8'h04;
    localparam logic [3:0] ADDR_MODE_PAGE = 4'h1;
    localparam int REQ_W = 5;
    localparam int REQ_INIT = 0;
    localparam int REQ_LVL_IN = 1;
    localparam int REQ_LVL_OUT = 2;
    localparam int REQ_VSW = 3;
    localparam int REQ_VSTABLE = 4;

    typedef enum logic [4:0] {
        S_IDLE, S_RELEASE, S_CKE_UP, S_MODE2, S_MODE3, S_MODE1, S_MODE0,
        S_CALIB, S_READY, S_LVL_IN, S_LVL, S_LVX_HOLD, S_LVX_TERM,
        S_LVX_MODE, S_VHOLD, S_WAIT
    } smr_cst_t;

    typedef struct packed {
        smr_cst_t st;
        smr_cst_t after;
        logic [CNT_W-1:0] cnt;
        logic mem_rst_n;
        logic cke;
        logic term;
        logic dqs_o;
        logic dqs_oe;
        logic [3:0] cmd;
        logic [BA_W-1:0] ba;
        logic [ADDR_W-1:0] addr;
        logic [3:0][ADDR_W-1:0] mode;
        logic [REQ_W-1:0] req;
        logic ready;
        logic lvl_result;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } smr_ctl_t;

    typedef struct packed {
        logic [3:0][ADDR_W-1:0] mode;
        logic [CNT_W-1:0] dll_cnt;
        logic dll_run;
        logic dll_lock;
        logic [CNT_W-1:0] cal_cnt;
        logic cal_run;
        logic cal_done;
        logic [CNT_W-1:0] upd_cnt;
        logic dq_undef;
        logic lvl_seen;
        logic dq_o;
        logic dq_oe;
        logic bst_valid;
        logic bst_eight;
        logic [COL_W-1:0] bst_block;
    } smr_dev_t;
endpackage
`default_nettype wire

/* verification/smr_link_sva.sv */
// link checker between the controller and device ends
`timescale 1ns/1ns
`default_nettype none
module smr_link_sva (
    // clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // link signals
    input wire logic mem_rst_n,
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [smr_pkg::BA_W-1:0] ba,
    input wire logic [smr_pkg::ADDR_W-1:0] addr,
    input wire logic term_ctl,
    input wire logic dqs_o,
    input wire logic dqs_oe
);
    import smr_pkg::*;
    logic [3:0] cmd;
    logic mw;
    logic oth;
    logic [3:0] upd_cnt_ff;
    logic [11:0] low_cnt_ff;
    // command decode
    assign cmd = {cs_n, ras_n, cas_n, we_n};
    assign mw = cke && cmd == CMD_MODE_WRITE;
    assign oth = cke && !cs_n && cmd != CMD_NOP && cmd != CMD_MODE_WRITE;
    // update window after a mode write, and memory reset low time
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            upd_cnt_ff <= 4'h0;
            low_cnt_ff <= 12'h000;
        end else begin
            if (mw) upd_cnt_ff <= 4'(MODE_UPD_CYC - 1);
            else if (upd_cnt_ff != 4'h0) upd_cnt_ff <= upd_cnt_ff - 4'h1;
            if (mem_rst_n) low_cnt_ff <= 12'h000;
            else if (low_cnt_ff != 12'hfff) low_cnt_ff <= low_cnt_ff + 12'h1;
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    AST_RST_PINS: assert property (!mem_rst_n |-> !term_ctl && !cke)
        else $error("termination or enable on in reset");
    AST_RST_LOW: assert property ($rose(mem_rst_n) |->
        low_cnt_ff >= 12'(RST_LOW_CYC)) else $error("reset low too short");
    AST_CKE_WAIT: assert property ($rose(mem_rst_n) |-> !cke [*8])
        else $error("enable rose too soon");
    AST_NOP_LOW: assert property (!cke |-> cmd == CMD_NOP)
        else $error("command while enable low");
    AST_CKE_HOLD: assert property (cke && mem_rst_n |=> cke)
        else $error("enable dropped");
    AST_FIRST: assert property ($rose(cke) |->
        !mw [*8] ##[1:8] (mw && ba == 3'h2)) else $error("first write");
    AST_ORDER: assert property (mw && ba == 3'h2 |->
        ##[4:8] (mw && ba == 3'h3) ##[4:8] (mw && ba == 3'h1)
        ##[4:8] (mw && ba == 3'h0)) else $error("mode write order");
    AST_GAP: assert property (mw |=> !mw [*3])
        else $error("mode writes too close");
    AST_UPD: assert property (oth |-> upd_cnt_ff == 4'h0)
        else $error("command inside update delay");
    AST_TERM: assert property (term_ctl |-> upd_cnt_ff == 4'h0 && !mw)
        else $error("termination on near mode write");
    AST_EXIT: assert property ($fell(dqs_oe) |-> !term_ctl &&
        !$past(dqs_o, 1) && !$past(dqs_o, 2)) else $error("strobe exit");
    AST_BA: assert property (mw |-> !ba[2])
        else $error("mode write to bad bank");
    AST_CAL: assert property (cke && cmd == CMD_CALIB |->
        addr[CALIB_LONG_BIT]) else $error("short calibration");
    // main scenarios reached
    cover property (mw && ba == 3'h2);
    cover property ($fell(dqs_oe));
    cover property (cke && cmd == CMD_CALIB);
endmodule // smr_link_sva
`default_nettype wire

/* verification/tb_sdram_init_mode_reg_sequencer.sv */
// bench joining controller and device ends, driven over apb
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin fails++; \
    $display("MISMATCH %s exp %h got %h", n, e, g); end end
module tb_sdram_init_mode_reg_sequencer;
    import smr_pkg::*;
    logic ref_clk = 0, resetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, dll_locked, calib_done, dq_undefined;
    logic [3:0][ADDR_W-1:0] mode_regs;
    logic [3:0][15:0] mv = {16'h0004, 16'h0018, 16'h0045, 16'h0121};
    // dll disable forced clear, dll reset bit self-clears in the device
    logic [3:0][15:0] ex = {16'h0004, 16'h0018, 16'h0044, 16'h0021};
    int fails = 0, checks = 0;
    smr_link_if link();
    // short enable-low wait keeps the run brief
    smr_ctrl #(.CKE_LOW_CYCLES(8)) i_smr_ctrl (.ref_clk, .resetn, .ce,
        .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
        .pslverr, .link);
    smr_dev i_smr_dev (.ref_clk, .resetn, .ce, .link, .mode_regs,
        .dll_locked, .calib_done, .dq_undefined, .burst_valid(),
        .burst_eight(), .burst_block());
    smr_link_sva i_smr_link_sva (.ref_clk, .resetn,
        .mem_rst_n(link.mem_rst_n), .cke(link.cke), .cs_n(link.cs_n),
        .ras_n(link.ras_n), .cas_n(link.cas_n), .we_n(link.we_n),
        .ba(link.ba), .addr(link.addr), .term_ctl(link.term_ctl),
        .dqs_o(link.dqs_o), .dqs_oe(link.dqs_oe));
    initial forever #50 ref_clk = ~ref_clk;
    // apb transfer; answer taken at the edge that sees pready
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // poll status until ready, bounded
    task wait_ready(input int n);
        int i;
        rd = 32'h0;
        for (i = 0; i < n && rd[0] !== 1'b1; i++) apb(1'b0, ADDR_STAT, 0);
    endtask
    task tally_and_finish;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // hang guard, far beyond init plus leveling plus switch
    initial begin
        repeat (30000) @(posedge ref_clk);
        fails++;
        tally_and_finish();
    end
    initial begin
        repeat (16) @(posedge ref_clk);
        resetn <= 1'b1;
        apb(1'b0, 8'h40, 0);
        `CHK("unmapped", 33'h100000000, {err, rd})
        // each write carries a whole register; upper half reads zero
        for (int k = 0; k < 4; k++) begin
            apb(1'b1, 8'h10 + 8'(4 * k), {16'hdead, mv[k]});
            apb(1'b0, 8'h10 + 8'(4 * k), 0);
            `CHK("mode readback", {16'h0, mv[k]}, rd)
        end
        apb(1'b1, ADDR_CTRL, 32'h1);
        wait_ready(3000);
        `CHK("init ready", 1'b1, rd[0])
        `CHK("mode regs", ex, mode_regs)
        `CHK("dll lock", 1'b1, dll_locked)
        `CHK("calib", 1'b1, calib_done)
        // leveling entry, then exit back to ready
        apb(1'b1, ADDR_CTRL, 32'h2);
        repeat (40) @(posedge ref_clk);
        `CHK("lvl bit", 1'b1, mode_regs[1][LVL_BIT])
        `CHK("dq drive", 1'b1, link.dq_oe)
        apb(1'b1, ADDR_CTRL, 32'h4);
        wait_ready(100);
        `CHK("lvl exit", 1'b1, rd[0])
        `CHK("mode one", ex[1], mode_regs[1])
        `CHK("dq defined", 1'b0, dq_undefined)
        `CHK("dq release", 1'b0, link.dq_oe)
        `CHK("lvl result", 1'b0, rd[1])
        // voltage switch: hold, then relock and recalibrate
        apb(1'b1, ADDR_CTRL, 32'h8);
        repeat (20) @(posedge ref_clk);
        apb(1'b0, ADDR_STAT, 0);
        `CHK("vsw hold", 1'b0, rd[0])
        apb(1'b1, ADDR_CTRL, 32'h10);
        // freeze both ends; the dll reset write must not go out meanwhile
        ce <= 1'b0;
        repeat (100) @(posedge ref_clk);
        `CHK("ce freeze", 1'b1, dll_locked)
        ce <= 1'b1;
        wait_ready(1000);
        `CHK("relock", 1'b1, rd[0] & dll_locked & calib_done)
        tally_and_finish();
    end
endmodule // tb_sdram_init_mode_reg_sequencer
`default_nettype wire
